//--- rtl/amp_fault_pkg.sv
//
// Contract
// - Global fault stops all channels, error low
// - Global latch cleared only by reset pulse
// - Channel fault stops only that channel
// - Reset low forces error output high
// - Current limit flips at fs/3, self-clears
// - Limit beyond 1.7 ms latches channel shutdown
// - Lost slave oscillator: Hi-Z, silent, self-recovers
// - Reset rising edge starts startup sequence
// - Pulse warning output while clipping
// - Thermal shutdown latched global, reset clears
// - Supply faults are self-clearing global faults
// - Power-on reset is self-clearing global fault
// - Thermal warning only on warning output
// - Warning asserted above warning threshold
// - Shutdown above shutdown threshold
// - Overvoltage: immediate Hi-Z, error low
package amp_fault_pkg;

    localparam int NUM_CH = 2;
    // Clock rate and overload timing
    localparam int CLK_HZ = 50000000;
    localparam int OVERLOAD_US = 1700;
    localparam int OVERLOAD_CYC = (CLK_HZ / 1000000) * OVERLOAD_US;
    localparam int OVL_W = 17;
    // Startup delay after reset release
    localparam int STARTUP_CYC = 64;
    localparam int START_W = 7;
    // Clip warning pulse length and period
    localparam int CLIP_PULSE_CYC = 25;
    localparam int CLIP_PERIOD_CYC = 100;
    localparam int CLIP_W = 7;
    // Current limit flips every third switching period
    localparam logic [1:0] FLIP_DIV = 2'h2;

    typedef struct packed {
        logic pvdd_uv;       // Power stage supply undervoltage
        logic pvdd_ov;       // Power stage supply overvoltage
        logic analog_supply_uv;       // Analog supply undervoltage
        logic por;           // Power-on reset active
        logic temp_warn;     // Above warning threshold
        logic temp_shut;     // Above shutdown threshold
        logic osc_lost;      // Slave oscillator stopped
    } global_cond_s;

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_RUN} run_state_e;

endpackage : amp_fault_pkg

//--- rtl/amp_fault_supervisor.sv
`timescale 1ns/1ps
module amp_fault_supervisor (
    input wire logic mclk,                                   // System clock, 50 MHz
    input wire logic rst,                                    // Synchronous reset
    input wire logic reset_pin_n,                            // Device reset pin
    input wire amp_fault_pkg::global_cond_s cond_in,         // Global fault conditions
    input wire logic [amp_fault_pkg::NUM_CH-1:0] overcur,    // Per-channel overcurrent
    input wire logic [amp_fault_pkg::NUM_CH-1:0] clipping,   // Per-channel clip detect
    input wire logic [amp_fault_pkg::NUM_CH-1:0] pwm_frame,  // Per-channel frame start
    input wire logic slave_mode,                             // Slave clock mode
    output logic [amp_fault_pkg::NUM_CH-1:0] ch_switch_en,   // Channel may switch
    output logic [amp_fault_pkg::NUM_CH-1:0] ch_hiz,         // Channel outputs Hi-Z
    output logic [amp_fault_pkg::NUM_CH-1:0] ch_flip,        // Bridge state flip
    output logic fault_n,                                    // Error output
    output logic thermal_clip_warn_n                         // Warning output
);

    //--------------------------------------------------------------------
    // Input synchronisers
    //--------------------------------------------------------------------
    localparam int SW = 8 + 3 * amp_fault_pkg::NUM_CH;
    logic [SW-1:0] raw_in;
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;

    assign raw_in = {reset_pin_n, cond_in, overcur, clipping, pwm_frame};

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    wire logic rpin;
    wire amp_fault_pkg::global_cond_s cs;
    wire logic [amp_fault_pkg::NUM_CH-1:0] oc_s;
    wire logic [amp_fault_pkg::NUM_CH-1:0] clip_s;
    wire logic [amp_fault_pkg::NUM_CH-1:0] frame_s;
    assign {rpin, cs, oc_s, clip_s, frame_s} = sync2_reg;

    //--------------------------------------------------------------------
    // Reset pin edge and startup sequence
    //--------------------------------------------------------------------
    logic rpin_d_reg;
    amp_fault_pkg::run_state_e state_reg, state_next;
    logic [amp_fault_pkg::START_W-1:0] start_cnt_reg, start_cnt_next;
    wire logic rpin_rise;

    assign rpin_rise = rpin & ~rpin_d_reg;

    always_comb begin
        state_next = state_reg;
        start_cnt_next = start_cnt_reg;
        if (!rpin) begin
            state_next = amp_fault_pkg::ST_IDLE;
            start_cnt_next = '0;
        end else begin
            unique case (state_reg)
                amp_fault_pkg::ST_IDLE: begin
                    if (rpin_rise) begin
                        state_next = amp_fault_pkg::ST_START;
                    end
                end
                amp_fault_pkg::ST_START: begin
                    start_cnt_next = start_cnt_reg + 1'b1;
                    if (start_cnt_reg == amp_fault_pkg::START_W'(amp_fault_pkg::STARTUP_CYC - 1)) begin
                        state_next = amp_fault_pkg::ST_RUN;
                    end
                end
                amp_fault_pkg::ST_RUN: begin
                    state_next = amp_fault_pkg::ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rpin_d_reg <= 1'b0;
            state_reg <= amp_fault_pkg::ST_IDLE;
            start_cnt_reg <= '0;
        end else begin
            rpin_d_reg <= rpin;
            state_reg <= state_next;
            start_cnt_reg <= start_cnt_next;
        end
    end

    //--------------------------------------------------------------------
    // Global fault decoding
    //--------------------------------------------------------------------
    logic therm_latch_reg;
    wire logic supply_fault;
    wire logic global_hiz;
    wire logic global_report;
    wire logic running;

    assign supply_fault = cs.pvdd_uv | cs.pvdd_ov | cs.analog_supply_uv | cs.por;
    assign global_hiz = supply_fault | therm_latch_reg | (slave_mode & cs.osc_lost);
    assign global_report = supply_fault | therm_latch_reg;
    assign running = (state_reg == amp_fault_pkg::ST_RUN);

    // thermal shutdown latch, cleared by reset low
    always_ff @(posedge mclk) begin
        if (rst) begin
            therm_latch_reg <= 1'b0;
        end else if (cs.temp_shut) begin
            therm_latch_reg <= 1'b1;
        end else if (!rpin) begin
            therm_latch_reg <= 1'b0;
        end
    end

    //--------------------------------------------------------------------
    // Per-channel current limit and overload
    //--------------------------------------------------------------------
    logic [amp_fault_pkg::NUM_CH-1:0] ovl_latch_reg;
    logic [amp_fault_pkg::NUM_CH-1:0] flip_reg;
    logic [amp_fault_pkg::NUM_CH-1:0] clip_any;

    genvar g;
    generate
        for (g = 0; g < amp_fault_pkg::NUM_CH; g++) begin : gen_ch
            logic [amp_fault_pkg::OVL_W-1:0] ovl_cnt_reg;
            logic [1:0] div_reg;
            logic [amp_fault_pkg::CLIP_W-1:0] clip_cnt_reg;
            wire logic ovl_hit;

            assign ovl_hit = (ovl_cnt_reg ==
                amp_fault_pkg::OVL_W'(amp_fault_pkg::OVERLOAD_CYC - 1));

            always_ff @(posedge mclk) begin
                if (rst || !oc_s[g] || !running) begin
                    ovl_cnt_reg <= '0;
                end else if (!ovl_hit) begin
                    ovl_cnt_reg <= ovl_cnt_reg + 1'b1;
                end
            end

            always_ff @(posedge mclk) begin
                if (rst) begin
                    ovl_latch_reg[g] <= 1'b0;
                end else if (ovl_hit && oc_s[g] && running) begin
                    ovl_latch_reg[g] <= 1'b1;
                end else if (!rpin) begin
                    ovl_latch_reg[g] <= 1'b0;
                end
            end

            // flip on every third frame while limiting
            always_ff @(posedge mclk) begin
                if (rst || !oc_s[g]) begin
                    div_reg <= 2'h0;
                    flip_reg[g] <= 1'b0;
                end else if (frame_s[g]) begin
                    div_reg <= (div_reg == amp_fault_pkg::FLIP_DIV) ? 2'h0 : div_reg + 2'h1;
                    flip_reg[g] <= (div_reg == amp_fault_pkg::FLIP_DIV);
                end
            end

            always_ff @(posedge mclk) begin
                if (rst || !clip_s[g]) begin
                    clip_cnt_reg <= '0;
                end else if (clip_cnt_reg ==
                    amp_fault_pkg::CLIP_W'(amp_fault_pkg::CLIP_PERIOD_CYC - 1)) begin
                    clip_cnt_reg <= '0;
                end else begin
                    clip_cnt_reg <= clip_cnt_reg + 1'b1;
                end
            end

            assign clip_any[g] = clip_s[g] &
                (clip_cnt_reg < amp_fault_pkg::CLIP_W'(amp_fault_pkg::CLIP_PULSE_CYC));
        end
    endgenerate

    //--------------------------------------------------------------------
    // Output registers
    //--------------------------------------------------------------------
    wire logic [amp_fault_pkg::NUM_CH-1:0] ch_stop;
    wire logic fault_next;
    wire logic warn_next;

    // global stops all, channel stops one
    assign ch_stop = {amp_fault_pkg::NUM_CH{global_hiz | ~running}} | ovl_latch_reg;
    // error output, forced high in reset
    assign fault_next = ~rpin | ~(global_report | (|ovl_latch_reg));
    assign warn_next = ~(cs.temp_warn | (|clip_any));

    always_ff @(posedge mclk) begin
        if (rst) begin
            ch_switch_en <= '0;
            ch_hiz <= '1;
            ch_flip <= '0;
            fault_n <= 1'b1;
            thermal_clip_warn_n <= 1'b1;
        end else begin
            ch_switch_en <= ~ch_stop;
            ch_hiz <= ch_stop;
            ch_flip <= flip_reg & ~ch_stop;
            fault_n <= fault_next;
            thermal_clip_warn_n <= warn_next;
        end
    end

endmodule : amp_fault_supervisor

//--- tb/amp_fault_props.sv
`timescale 1ns/1ps
// ----------
// Supervisor checks
// ----------
module amp_fault_props (
    input wire logic mclk, // Clock
    input wire logic rst, // Sync reset
    input wire logic reset_pin_n, // Reset pin
    input wire amp_fault_pkg::global_cond_s cond_in, // Global conditions
    input wire logic [1:0] overcur, // Overcurrent
    input wire logic [1:0] clipping, // Clip detect
    input wire logic [1:0] pwm_frame, // Frame start
    input wire logic slave_mode, // Slave clock mode
    input wire logic [1:0] ch_switch_en, // Switching
    input wire logic [1:0] ch_hiz, // Hi-Z
    input wire logic [1:0] ch_flip, // Bridge flip
    input wire logic fault_n, // Error output
    input wire logic thermal_clip_warn_n // Warning output
);
    logic [7:0] clip_hi_cnt;
    logic [6:0] pin_hi_cnt;
    logic any_global;
    // Stopping conditions that also pull the error output low (not the warning or oscillator loss)
    assign any_global = cond_in.pvdd_uv | cond_in.pvdd_ov | cond_in.analog_supply_uv | cond_in.por |
        cond_in.temp_shut;
    // Run lengths of warning high while clipping, and of the reset pin high
    always_ff @(posedge mclk) begin
        clip_hi_cnt <= (rst || clipping == 2'h0 || !thermal_clip_warn_n) ? 8'h00 : clip_hi_cnt + 8'h01;
        pin_hi_cnt <= (rst || !reset_pin_n) ? 7'h00 : pin_hi_cnt + {6'h00, pin_hi_cnt != 7'h7f};
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_pin_low; !reset_pin_n [*4]; endsequence
    sequence s_global; (reset_pin_n && any_global) [*4]; endsequence
    a_hiz_mirror: assert property (ch_hiz == ~ch_switch_en) else $error("hiz mismatch");
    a_reset_high: assert property (s_pin_low |=> fault_n) else $error("fault in reset");
    a_global_stop: assert property (s_global |=> !fault_n && ch_hiz == 2'h3)
        else $error("global fault missed");
    a_warn_shown: assert property (cond_in.temp_warn [*4] |=> !thermal_clip_warn_n)
        else $error("warning missed");
    a_osc_hiz: assert property ((slave_mode && cond_in.osc_lost) [*4] |=> ch_hiz == 2'h3)
        else $error("osc loss not hiz");
    a_clip_pulses: assert property (clip_hi_cnt < 8'h78) else $error("no clip pulse");
    a_startup_wait: assert property ($rose(ch_switch_en[0]) |-> pin_hi_cnt >= 7'h40)
        else $error("switching too early");
    a_flip_frame: assert property ($rose(ch_flip[0]) |-> $past(pwm_frame[0], 3) ||
        $past(pwm_frame[0], 4) || $past(pwm_frame[0], 5)) else $error("flip without frame");
endmodule : amp_fault_props
bind amp_fault_supervisor amp_fault_props i_props (.mclk, .rst, .reset_pin_n, .cond_in,
    .overcur, .clipping, .pwm_frame, .slave_mode, .ch_switch_en, .ch_hiz, .ch_flip, .fault_n,
    .thermal_clip_warn_n);

//--- tb/mcu_reset_model.sv
`timescale 1ns/1ps
module mcu_reset_model (
    input wire logic mclk, // Clock
    input wire logic thermal_clip_warn_n, // Warning from device
    input wire logic restart_req, // Bench asks for a restart
    output logic reset_pin_n // Reset pin to device
);
    logic [7:0] low_cnt = 8'h00;
    initial reset_pin_n = 1'b0;
    // Pulse reset low, then release it with a rising edge
    // restart when cool
    always @(posedge mclk) begin
        if (restart_req) begin
            reset_pin_n <= 1'b0;
            low_cnt <= 8'h00;
        end else if (!reset_pin_n) begin
            low_cnt <= low_cnt + 8'h01;
            if (low_cnt >= 8'h08 && thermal_clip_warn_n) begin
                reset_pin_n <= 1'b1;
            end
        end
    end
endmodule : mcu_reset_model

//--- tb/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module tb;
    logic mclk = 1'b0, rst = 1'b1, slave_mode = 1'b0, restart_req = 1'b0;
    amp_fault_pkg::global_cond_s cond_in = 7'h00;
    logic [1:0] overcur = 2'h0, clipping = 2'h0, pwm_frame = 2'h0;
    logic [1:0] ch_switch_en, ch_hiz, ch_flip;
    logic reset_pin_n, fault_n, thermal_clip_warn_n;
    int mismatches = 0, num_checks = 0, flips0 = 0, flips1 = 0, warn_lows = 0, i;
    logic [1:0] flip_d = 2'h0;
    amp_fault_supervisor i_dut (.mclk, .rst, .reset_pin_n, .cond_in, .overcur, .clipping,
        .pwm_frame, .slave_mode, .ch_switch_en, .ch_hiz, .ch_flip, .fault_n, .thermal_clip_warn_n);
    mcu_reset_model i_mcu (.mclk, .thermal_clip_warn_n, .restart_req, .reset_pin_n);
    initial forever #10 mclk = ~mclk;
    // Count flip onsets (flip holds until next frame) and warning-low cycles
    always @(negedge mclk) begin
        flips0 += int'(ch_flip[0] & ~flip_d[0]);
        flips1 += int'(ch_flip[1] & ~flip_d[1]);
        flip_d = ch_flip;
        warn_lows += int'(!thermal_clip_warn_n);
    end
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic wait_run();
        int k;
        for (k = 0; k < 300 && ch_switch_en !== 2'h3; k++) step(1);
        if (k == 300) begin
            `CHK("ch_switch_en", 2'h3, ch_switch_en)
            finish_test();
        end
    endtask : wait_run
    task automatic restart();
        restart_req = 1'b1;
        step(1);
        restart_req = 1'b0;
        step(5);
        wait_run();
    endtask : restart
    // ----------
    // Scenarios
    // ----------
    initial begin
        step(5);
        rst = 1'b0;
        step(40);
        `CHK("ch_switch_en", 2'h0, ch_switch_en)
        wait_run();
        for (i = 0; i < 4; i++) begin
            cond_in = 7'h40 >> i;
            step(6);
            `CHK("fault_n", 1'b0, fault_n)
            `CHK("ch_hiz", 2'h3, ch_hiz)
            cond_in = 7'h00;
            wait_run();
            `CHK("fault_n", 1'b1, fault_n)
        end
        cond_in = 7'h04;
        step(6);
        `CHK("warn_n", 1'b0, thermal_clip_warn_n)
        `CHK("ch_switch_en", 2'h3, ch_switch_en)
        `CHK("fault_n", 1'b1, fault_n)
        cond_in = 7'h06;
        step(6);
        `CHK("ch_hiz", 2'h3, ch_hiz)
        cond_in = 7'h04;
        step(20);
        `CHK("fault_n", 1'b0, fault_n)
        restart_req = 1'b1;
        step(1);
        restart_req = 1'b0;
        step(40);
        `CHK("reset_pin_n", 1'b0, reset_pin_n)
        `CHK("fault_n", 1'b1, fault_n)
        cond_in = 7'h00;
        wait_run();
        `CHK("fault_n", 1'b1, fault_n)
        `CHK("warn_n", 1'b1, thermal_clip_warn_n)
        cond_in = 7'h01;
        step(6);
        `CHK("ch_switch_en", 2'h3, ch_switch_en)
        slave_mode = 1'b1;
        step(6);
        `CHK("ch_hiz", 2'h3, ch_hiz)
        `CHK("fault_n", 1'b1, fault_n)
        cond_in = 7'h00;
        wait_run();
        overcur = 2'h1;
        step(4);
        flips0 = 0;
        flips1 = 0;
        repeat (9) begin
            pwm_frame = 2'h3;
            step(1);
            pwm_frame = 2'h0;
            step(4);
        end
        step(6);
        `CHK("flips0", 3, flips0)
        `CHK("flips1", 0, flips1)
        `CHK("fault_n", 1'b1, fault_n)
        overcur = 2'h0;
        clipping = 2'h2;
        step(10);
        warn_lows = 0;
        step(200);
        `CHK("warn_lows", 50, warn_lows)
        clipping = 2'h0;
        step(30);
        `CHK("warn_n", 1'b1, thermal_clip_warn_n)
        overcur = 2'h2;
        step(84980);
        `CHK("ch_switch_en", 2'h3, ch_switch_en)
        step(40);
        `CHK("ch_hiz", 2'h2, ch_hiz)
        `CHK("fault_n", 1'b0, fault_n)
        overcur = 2'h0;
        step(10);
        `CHK("fault_n", 1'b0, fault_n)
        restart();
        `CHK("fault_n", 1'b1, fault_n)
        finish_test();
    end
endmodule : tb
